// File: design/clk_reg_bank.sv
// register bank with staged multi-byte fields, status latching and bank switching
`timescale 1ns/1ps
module clk_reg_bank #(
  parameter int                 N_EVT     = 8,
  parameter logic [N_EVT-1:0]   EDGE_RISE = '1,
  parameter logic [N_EVT-1:0]   EDGE_FALL = '0
) (
  input  wire logic                                       REF_CLK,
  input  wire logic                                       RST_N,
  input  wire logic [clk_regs_pkg::ADDR_W-1:0]            REG_ADDR,
  input  wire logic [clk_regs_pkg::DATA_W-1:0]            REG_WDATA,
  input  wire logic                                       REG_WR,
  input  wire logic                                       REG_RD,
  output logic      [clk_regs_pkg::DATA_W-1:0]            REG_RDATA,
  output logic                                            RD_VALID,
  input  wire logic [N_EVT-1:0]                           EVT_IN,
  input  wire logic [7:0]                                 STRAP,
  input  wire logic [clk_regs_pkg::WORD_W-1:0]            MEAS_MEASURED_WORD_A,
  input  wire logic [clk_regs_pkg::WORD_W-1:0]            MEAS_PHASE,
  output logic      [clk_regs_pkg::ADDR_W-1:0]            EE_ADDR,
  output logic      [clk_regs_pkg::DATA_W-1:0]            EE_WDATA,
  output logic                                            EE_WR,
  output logic                                            EE_RD,
  input  wire logic [clk_regs_pkg::DATA_W-1:0]            EE_RDATA,
  output logic      [clk_regs_pkg::CFG_DEPTH-1:0][7:0]    CFG_OUT,
  output logic      [clk_regs_pkg::DPLL_MEASURED_WORD_A_SETTING_W-1:0]           DPLL_MEASURED_WORD_A_SETTING_OUT,
  output logic      [clk_regs_pkg::WORD_W-1:0]            PHASE_OFFSET_WORD_OUT,
  output logic                                            SOFT_RST,
  output logic                                            IRQ
);

  typedef struct packed {
    logic [clk_regs_pkg::CFG_DEPTH-1:0][7:0] cfg;
    logic [clk_regs_pkg::DPLL_MEASURED_WORD_A_SETTING_W-1:0]        dpll_measured_word_a_setting;
    logic [clk_regs_pkg::WORD_W-1:0]         phase_offset_word;
    logic [clk_regs_pkg::DPLL_MEASURED_WORD_A_SETTING_W-1:0]        wstage;
    logic [clk_regs_pkg::DPLL_MEASURED_WORD_A_SETTING_W-1:0]        rsnap;
    logic [N_EVT-1:0]                        prev;
    logic [N_EVT-1:0]                        latched;
    logic [N_EVT-1:0]                        irq_en;
    logic [7:0]                              strap;
    logic                                    strap_done;
    logic                                    ee_pend;
    logic [clk_regs_pkg::DATA_W-1:0]         rdata;
    logic                                    rd_valid;
    logic [clk_regs_pkg::ADDR_W-1:0]         ee_addr;
    logic [clk_regs_pkg::DATA_W-1:0]         ee_wdata;
    logic                                    ee_wr;
    logic                                    ee_rd;
    logic                                    irq;
  } state_t;

  state_t st_q;
  state_t st_d;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  // which staged field an address falls in
  function automatic clk_regs_pkg::mb_field_t mb_field(input logic [8:0] a);
    if (a >= clk_regs_pkg::DPLL_MEASURED_WORD_A_SETTING_BASE && a < clk_regs_pkg::DPLL_MEASURED_WORD_A_SETTING_BASE + clk_regs_pkg::DPLL_MEASURED_WORD_A_SETTING_BYTES) begin
      return clk_regs_pkg::MB_DPLL_MEASURED_WORD_A_SETTING;
    end else if (a >= clk_regs_pkg::PHASE_OFFSET_WORD_BASE && a < clk_regs_pkg::PHASE_OFFSET_WORD_BASE + clk_regs_pkg::WORD_BYTES) begin
      return clk_regs_pkg::MB_PHASE_OFFSET_WORD;
    end else if (a >= clk_regs_pkg::MEAS_MEASURED_WORD_A_BASE
                 && a < clk_regs_pkg::MEAS_MEASURED_WORD_A_BASE + clk_regs_pkg::WORD_BYTES) begin
      return clk_regs_pkg::MB_MFREQ;
    end else if (a >= clk_regs_pkg::MEAS_PHASE_BASE
                 && a < clk_regs_pkg::MEAS_PHASE_BASE + clk_regs_pkg::WORD_BYTES) begin
      return clk_regs_pkg::MB_MPHASE;
    end else begin
      return clk_regs_pkg::MB_NONE;
    end
  endfunction

  // byte index within the field, lowest address is zero
  function automatic logic [2:0] mb_index(input logic [8:0] a, input clk_regs_pkg::mb_field_t f);
    logic [8:0] base;
    base = clk_regs_pkg::DPLL_MEASURED_WORD_A_SETTING_BASE;
    case (f)
      clk_regs_pkg::MB_PHASE_OFFSET_WORD:  base = clk_regs_pkg::PHASE_OFFSET_WORD_BASE;
      clk_regs_pkg::MB_MFREQ:  base = clk_regs_pkg::MEAS_MEASURED_WORD_A_BASE;
      clk_regs_pkg::MB_MPHASE: base = clk_regs_pkg::MEAS_PHASE_BASE;
      default:                 base = clk_regs_pkg::DPLL_MEASURED_WORD_A_SETTING_BASE;
    endcase
    return 3'(a - base);
  endfunction

  logic                           bank_ee;
  clk_regs_pkg::mb_field_t        fld;
  logic [2:0]                     idx;
  logic [2:0]                     last_idx;
  logic [clk_regs_pkg::DPLL_MEASURED_WORD_A_SETTING_W-1:0] fld_now;
  logic [N_EVT-1:0]               ev_set;
  logic [N_EVT-1:0]               ev_clr;
  logic [4:0]                     ci;

  assign bank_ee = st_q.cfg[0][clk_regs_pkg::BANK_BIT] && REG_ADDR != clk_regs_pkg::BANK_SELECT_ADDR;
  assign fld     = mb_field(REG_ADDR);
  assign idx     = mb_index(REG_ADDR, fld);
  assign ci      = REG_ADDR[4:0];
  assign last_idx = (fld == clk_regs_pkg::MB_DPLL_MEASURED_WORD_A_SETTING) ? 3'h4 : 3'h3;

  always_comb begin
    fld_now = '0;
    case (fld)
      clk_regs_pkg::MB_DPLL_MEASURED_WORD_A_SETTING:  fld_now = st_q.dpll_measured_word_a_setting;
      clk_regs_pkg::MB_PHASE_OFFSET_WORD:  fld_now = {8'h00, st_q.phase_offset_word};
      clk_regs_pkg::MB_MFREQ:  fld_now = {8'h00, MEAS_MEASURED_WORD_A};
      clk_regs_pkg::MB_MPHASE: fld_now = {8'h00, MEAS_PHASE};
      default:                 fld_now = '0;
    endcase
  end

  always_comb begin
    st_d          = st_q;
    st_d.rd_valid = 1'b0;
    st_d.ee_wr    = 1'b0;
    st_d.ee_rd    = 1'b0;
    ev_clr        = '0;
    // edges only count once the previous level has been seen after reset
    ev_set = st_q.strap_done ? (((EVT_IN & ~st_q.prev) & EDGE_RISE)
                               | ((~EVT_IN & st_q.prev) & EDGE_FALL)) : '0;
    st_d.prev = EVT_IN;

    // pin-programmed field taken on the first edge after hardware reset
    if (!st_q.strap_done) begin
      st_d.strap_done = 1'b1;
      st_d.strap      = STRAP;
      st_d.cfg[clk_regs_pkg::PIN_FUNC_CFG_1_ADDR[4:0]] = STRAP;
    end

    // eeprom bank answers one cycle after its strobe
    if (st_q.ee_pend) begin
      st_d.ee_pend  = 1'b0;
      st_d.rdata    = EE_RDATA;
      st_d.rd_valid = 1'b1;
    end

    if (REG_WR) begin
      if (bank_ee) begin
        st_d.ee_wr    = 1'b1;
        st_d.ee_addr  = REG_ADDR;
        st_d.ee_wdata = REG_WDATA;
      end else if (REG_ADDR <= clk_regs_pkg::CFG_LAST_ADDR) begin
        st_d.cfg[ci] = (st_d.cfg[ci] & ~clk_regs_pkg::CFG_MASK[ci])
                     | (REG_WDATA & clk_regs_pkg::CFG_MASK[ci]);
      end else if (REG_ADDR == clk_regs_pkg::STATUS_LATCHED_ADDR) begin
        ev_clr = REG_WDATA[N_EVT-1:0];
      end else if (REG_ADDR == clk_regs_pkg::STATUS_IRQ_EN_ADDR) begin
        st_d.irq_en = REG_WDATA[N_EVT-1:0];
      end else if (fld == clk_regs_pkg::MB_DPLL_MEASURED_WORD_A_SETTING || fld == clk_regs_pkg::MB_PHASE_OFFSET_WORD) begin
        st_d.rsnap[idx*8 +: 8] = REG_WDATA;
        if (idx == last_idx) begin
          // whole field moves together so the consumer never sees a torn value
          if (fld == clk_regs_pkg::MB_DPLL_MEASURED_WORD_A_SETTING) begin
            st_d.dpll_measured_word_a_setting = {REG_WDATA, st_q.wstage[31:0]};
          end else begin
            st_d.phase_offset_word = {REG_WDATA, st_q.wstage[23:0]};
          end
        end else begin
          st_d.wstage[idx*8 +: 8] = REG_WDATA;
        end
      end
    end

    if (REG_RD) begin
      if (bank_ee) begin
        st_d.ee_rd   = 1'b1;
        st_d.ee_addr = REG_ADDR;
        st_d.ee_pend = 1'b1;
      end else begin
        st_d.rd_valid = 1'b1;
        st_d.rdata    = 8'h00;
        if (REG_ADDR <= clk_regs_pkg::CFG_LAST_ADDR) begin
          st_d.rdata = st_q.cfg[ci];
        end else if (REG_ADDR == clk_regs_pkg::STATUS_LIVE_ADDR) begin
          st_d.rdata[N_EVT-1:0] = EVT_IN;
        end else if (REG_ADDR == clk_regs_pkg::STATUS_LATCHED_ADDR) begin
          st_d.rdata[N_EVT-1:0] = st_q.latched;
        end else if (REG_ADDR == clk_regs_pkg::STATUS_IRQ_EN_ADDR) begin
          st_d.rdata[N_EVT-1:0] = st_q.irq_en;
        end else if (fld != clk_regs_pkg::MB_NONE) begin
          if (idx == 3'h0) begin
            st_d.rdata = fld_now[7:0];
            st_d.rsnap = fld_now;
          end else begin
            st_d.rdata = st_q.rsnap[idx*8 +: 8];
          end
        end
      end
    end

    // set wins over a clear in the same cycle
    st_d.latched = (st_q.latched & ~ev_clr) | ev_set;

    // soft reset spares bank select, the reset bit and the bus answer path
    if (st_q.cfg[clk_regs_pkg::MASTER_CTRL_1_ADDR[4:0]][clk_regs_pkg::SOFT_RST_BIT]) begin
      for (int i = 1; i < clk_regs_pkg::CFG_DEPTH; i++) begin
        if (i != int'(clk_regs_pkg::MASTER_CTRL_1_ADDR)) begin
          st_d.cfg[i] = clk_regs_pkg::CFG_RESET[i];
        end
      end
      st_d.cfg[clk_regs_pkg::MASTER_CTRL_1_ADDR[4:0]][6:0] = 7'h00;
      st_d.cfg[clk_regs_pkg::PIN_FUNC_CFG_1_ADDR[4:0]] = st_q.strap;
      st_d.dpll_measured_word_a_setting   = clk_regs_pkg::DPLL_MEASURED_WORD_A_SETTING_RESET;
      st_d.phase_offset_word   = clk_regs_pkg::PHASE_OFFSET_WORD_RESET;
      st_d.latched = '0;
      st_d.irq_en  = '0;
    end

    st_d.irq = |(st_d.latched & st_d.irq_en);
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      st_q       <= '0;
      st_q.cfg   <= clk_regs_pkg::CFG_RESET;
      st_q.dpll_measured_word_a_setting <= clk_regs_pkg::DPLL_MEASURED_WORD_A_SETTING_RESET;
      st_q.phase_offset_word <= clk_regs_pkg::PHASE_OFFSET_WORD_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign REG_RDATA = st_q.rdata;
  assign RD_VALID  = st_q.rd_valid;
  assign EE_ADDR   = st_q.ee_addr;
  assign EE_WDATA  = st_q.ee_wdata;
  assign EE_WR     = st_q.ee_wr;
  assign EE_RD     = st_q.ee_rd;
  assign CFG_OUT   = st_q.cfg;
  assign DPLL_MEASURED_WORD_A_SETTING_OUT = st_q.dpll_measured_word_a_setting;
  assign PHASE_OFFSET_WORD_OUT = st_q.phase_offset_word;
  assign SOFT_RST  = st_q.cfg[clk_regs_pkg::MASTER_CTRL_1_ADDR[4:0]][clk_regs_pkg::SOFT_RST_BIT];
  assign IRQ       = st_q.irq;

  a_unmapped_zero: assert property (
    (REG_RD && !REG_WR && REG_ADDR[8] && !st_q.cfg[0][0] && !st_q.ee_pend)
      |=> (RD_VALID && REG_RDATA == 8'h00))
    else $error("unmapped address did not read zero");

  a_live_read: assert property (
    (REG_RD && REG_ADDR == clk_regs_pkg::STATUS_LIVE_ADDR && !st_q.cfg[0][0] && !st_q.ee_pend)
      |=> (REG_RDATA[N_EVT-1:0] == $past(EVT_IN)))
    else $error("live status did not return current level");

  a_zero_keeps: assert property (
    (REG_WR && REG_ADDR == clk_regs_pkg::STATUS_LATCHED_ADDR && REG_WDATA == 8'h00 && !st_q.cfg[0][0]
      && !SOFT_RST) |=> (($past(st_q.latched) & ~st_q.latched) == '0))
    else $error("writing zero cleared a latched bit");

  a_one_clears: assert property (
    (REG_WR && REG_ADDR == clk_regs_pkg::STATUS_LATCHED_ADDR && REG_WDATA == 8'hFF && !st_q.cfg[0][0]
      && EVT_IN == st_q.prev) |=> (st_q.latched == '0 && !IRQ))
    else $error("write one did not clear latched bits");

  a_irq_masked: assert property (
    (st_q.irq_en == '0) [*2] |-> !IRQ)
    else $error("interrupt raised with all enables off");

  a_stage_holds: assert property (
    (REG_WR && REG_ADDR == clk_regs_pkg::DPLL_MEASURED_WORD_A_SETTING_BASE && !st_q.cfg[0][0] && !SOFT_RST) |=> $stable(DPLL_MEASURED_WORD_A_SETTING_OUT))
    else $error("staged byte changed live field");

  a_last_commits: assert property (
    (REG_WR && REG_ADDR == clk_regs_pkg::DPLL_MEASURED_WORD_A_SETTING_BASE + 9'h004 && !st_q.cfg[0][0] && !SOFT_RST)
      |=> (DPLL_MEASURED_WORD_A_SETTING_OUT == {$past(REG_WDATA), $past(st_q.wstage[31:0])}))
    else $error("last byte did not commit field");

  a_first_snaps: assert property (
    (REG_RD && !REG_WR && REG_ADDR == clk_regs_pkg::MEAS_MEASURED_WORD_A_BASE && !st_q.cfg[0][0])
      |=> (st_q.rsnap[31:0] == $past(MEAS_MEASURED_WORD_A)))
    else $error("first byte read did not snapshot field");

  a_bank_route: assert property (
    (REG_RD && st_q.cfg[0][0] && REG_ADDR != 9'h000) |=> EE_RD ##1 RD_VALID)
    else $error("eeprom bank read not routed");

  a_soft_reset: assert property (
    SOFT_RST |=> (DPLL_MEASURED_WORD_A_SETTING_OUT == clk_regs_pkg::DPLL_MEASURED_WORD_A_SETTING_RESET && st_q.latched == '0))
    else $error("soft reset did not restore fields");

  a_fixed_bits: assert property (
    ((CFG_OUT ^ clk_regs_pkg::CFG_RESET) & ~clk_regs_pkg::CFG_MASK) == '0)
    else $error("fixed or reserved configuration bit changed");

  a_edge_sets: assert property (
    (st_q.strap_done && !SOFT_RST && EDGE_RISE[0] && EVT_IN[0] && !st_q.prev[0]) |=> st_q.latched[0])
    else $error("rising edge did not set latched bit");

  a_reset_defaults: assert property (
    $rose(RST_N) |-> (CFG_OUT == clk_regs_pkg::CFG_RESET && DPLL_MEASURED_WORD_A_SETTING_OUT == clk_regs_pkg::DPLL_MEASURED_WORD_A_SETTING_RESET
      && PHASE_OFFSET_WORD_OUT == clk_regs_pkg::PHASE_OFFSET_WORD_RESET && !IRQ))
    else $error("reset did not restore defaults");

  a_mid_write_read: assert property (
    (REG_RD && !REG_WR && REG_ADDR == clk_regs_pkg::DPLL_MEASURED_WORD_A_SETTING_BASE && !st_q.cfg[0][0] && !st_q.ee_pend)
      |=> (REG_RDATA == $past(DPLL_MEASURED_WORD_A_SETTING_OUT[7:0])))
    else $error("read during staged write did not return committed byte");

  a_snap_overwrite: assert property (
    (REG_WR && !REG_RD && REG_ADDR == clk_regs_pkg::DPLL_MEASURED_WORD_A_SETTING_BASE + 9'h001 && !st_q.cfg[0][0])
      |=> (st_q.rsnap[15:8] == $past(REG_WDATA)))
    else $error("write during read did not overwrite snapshot byte");

  a_phase_offset_word_commit: assert property (
    (REG_WR && REG_ADDR == clk_regs_pkg::PHASE_OFFSET_WORD_BASE + 9'h003 && !st_q.cfg[0][0] && !SOFT_RST)
      |=> (PHASE_OFFSET_WORD_OUT == {$past(REG_WDATA), $past(st_q.wstage[23:0])}))
    else $error("last byte did not commit phase offset");

  a_meas_ignored: assert property (
    (REG_WR && !REG_RD && REG_ADDR == clk_regs_pkg::MEAS_PHASE_BASE && !st_q.cfg[0][0])
      |=> $stable(st_q.rsnap))
    else $error("write to measured field changed snapshot");

  a_ee_write: assert property (
    (REG_WR && st_q.cfg[0][0] && REG_ADDR != clk_regs_pkg::BANK_SELECT_ADDR)
      |=> (EE_WR && EE_ADDR == $past(REG_ADDR) && EE_WDATA == $past(REG_WDATA)))
    else $error("eeprom bank write not routed");

endmodule

// File: design/clk_regs_pkg.sv
// constants for the clock chip register bank
package clk_regs_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int CFG_DEPTH = 32;
  localparam int DPLL_MEASURED_WORD_A_SETTING_W = 40;
  localparam int WORD_W = 32;

  localparam logic [8:0] BANK_SELECT_ADDR = 9'h000;
  localparam logic [8:0] MASTER_CTRL_1_ADDR = 9'h009;
  localparam logic [8:0] PIN_FUNC_CFG_1_ADDR = 9'h00E;
  localparam logic [8:0] CFG_LAST_ADDR = 9'h01F;
  localparam logic [8:0] STATUS_LIVE_ADDR = 9'h041;
  localparam logic [8:0] STATUS_LATCHED_ADDR = 9'h042;
  localparam logic [8:0] STATUS_IRQ_EN_ADDR = 9'h043;
  localparam logic [8:0] DPLL_MEASURED_WORD_A_SETTING_BASE = 9'h060;
  localparam logic [8:0] MEAS_MEASURED_WORD_A_BASE = 9'h065;
  localparam logic [8:0] PHASE_OFFSET_WORD_BASE = 9'h070;
  localparam logic [8:0] MEAS_PHASE_BASE = 9'h07D;
  localparam logic [8:0] DPLL_MEASURED_WORD_A_SETTING_BYTES = 9'h005;
  localparam logic [8:0] WORD_BYTES = 9'h004;

  localparam int BANK_BIT = 0;
  localparam int SOFT_RST_BIT = 7;

  // writable bits per configuration byte; fixed-value and reserved bits stay at reset value
  localparam logic [CFG_DEPTH-1:0][7:0] CFG_MASK = '{
    31: 8'h9F, 30: 8'h9F, 29: 8'hC7, 28: 8'hFF, 27: 8'hE3,
    21: 8'hFF, 20: 8'hFF, 19: 8'hFF, 18: 8'hFF, 15: 8'hFF, 14: 8'hFF,
    13: 8'h07, 12: 8'h07, 11: 8'h11, 10: 8'h77, 9: 8'hBF, 0: 8'h01,
    default: 8'h00};
  localparam logic [CFG_DEPTH-1:0][7:0] CFG_RESET = '{12: 8'h08, 11: 8'h44, default: 8'h00};
  localparam logic [DPLL_MEASURED_WORD_A_SETTING_W-1:0] DPLL_MEASURED_WORD_A_SETTING_RESET = 40'h00_0000_0000;
  localparam logic [WORD_W-1:0] PHASE_OFFSET_WORD_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {MB_NONE, MB_DPLL_MEASURED_WORD_A_SETTING, MB_PHASE_OFFSET_WORD, MB_MFREQ, MB_MPHASE} mb_field_t;
endpackage

// File: test/test_clk_reg_bank.sv
// self-checking bench for the clock chip register bank
`timescale 1ns/1ps
module test_clk_reg_bank;
  logic             ref_clk = 1'b0;
  logic             rst_n;
  logic [8:0]       reg_addr;
  logic [7:0]       reg_wdata;
  logic             reg_wr;
  logic             reg_rd;
  logic [7:0]       reg_rdata;
  logic             rd_valid;
  logic [7:0]       evt_in;
  logic [7:0]       strap;
  logic [31:0]      meas_measured_word_a;
  logic [31:0]      meas_phase;
  logic [8:0]       ee_addr;
  logic [7:0]       ee_wdata;
  logic             ee_wr;
  logic             ee_rd;
  logic [7:0]       ee_rdata;
  logic [31:0][7:0] cfg_out;
  logic [39:0]      dpll_measured_word_a_setting_out;
  logic [31:0]      phase_offset_word_out;
  logic             soft_rst;
  logic             irq;
  logic [7:0]       exp_q[$];
  int               bad_count = 0;
  int               n_compared = 0;
  logic [39:0]      fz;
  logic [31:0]      wa;
  logic [7:0]       w;
  logic [7:0]       wmask;
  logic [8:0]       cfg_list[12] = '{9'h009, 9'h00A, 9'h00B, 9'h00C, 9'h00D, 9'h00F, 9'h012, 9'h015,
                                     9'h01B, 9'h01D, 9'h01F, 9'h003};

  always #2.5 ref_clk = ~ref_clk;
  // idle pattern differs from a real answer so a late sample shows up
  assign ee_rdata = ee_rd ? (ee_addr[7:0] ^ 8'hA5) : ~(ee_addr[7:0] ^ 8'hA5);

  clk_reg_bank dut (
    .REF_CLK   (ref_clk),
    .RST_N     (rst_n),
    .REG_ADDR  (reg_addr),
    .REG_WDATA (reg_wdata),
    .REG_WR    (reg_wr),
    .REG_RD    (reg_rd),
    .REG_RDATA (reg_rdata),
    .RD_VALID  (rd_valid),
    .EVT_IN    (evt_in),
    .STRAP     (strap),
    .MEAS_MEASURED_WORD_A (meas_measured_word_a),
    .MEAS_PHASE(meas_phase),
    .EE_ADDR   (ee_addr),
    .EE_WDATA  (ee_wdata),
    .EE_WR     (ee_wr),
    .EE_RD     (ee_rd),
    .EE_RDATA  (ee_rdata),
    .CFG_OUT   (cfg_out),
    .DPLL_MEASURED_WORD_A_SETTING_OUT (dpll_measured_word_a_setting_out),
    .PHASE_OFFSET_WORD_OUT (phase_offset_word_out),
    .SOFT_RST  (soft_rst),
    .IRQ       (irq)
  );

  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // two idle edges cover the slower eeprom answer
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  function automatic logic [7:0] exp_cfg(input logic [8:0] a, input logic [7:0] d);
    logic [7:0] m;
    m = clk_regs_pkg::CFG_MASK[a[4:0]];
    return (clk_regs_pkg::CFG_RESET[a[4:0]] & ~m) | (d & m);
  endfunction

  always @(posedge ref_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("read answer", 40'h1, 40'h0);
      end else begin
        check("reg_rdata", reg_rdata, exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    summarize();
  end

  initial begin
    void'($urandom(32'h967C));
    rst_n = 1'b0;
    reg_addr = 9'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    evt_in = 8'h00;
    strap = 8'($urandom);
    meas_measured_word_a = $urandom;
    meas_phase = $urandom;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(9'h00B, 8'h44);
    rd(9'h00C, 8'h08);
    rd(9'h00E, strap);
    foreach (cfg_list[i]) begin
      w = 8'($urandom);
      if (cfg_list[i] == 9'h009) w[7] = 1'b0;
      wmask = clk_regs_pkg::CFG_MASK[cfg_list[i][4:0]];
      w = (w & wmask) | (clk_regs_pkg::CFG_RESET[cfg_list[i][4:0]] & ~wmask);
      wr(cfg_list[i], w);
      check("cfg_out", cfg_out[cfg_list[i][4:0]], exp_cfg(cfg_list[i], w));
      rd(cfg_list[i], exp_cfg(cfg_list[i], w));
    end
    wr(9'h1F3, 8'h00);
    rd(9'h1F3, 8'h00);
    wr(9'h00E, ~strap);
    rd(9'h00E, ~strap);
    fz = {8'($urandom), 32'($urandom)};
    for (int i = 0; i < 4; i++) wr(9'h060 + 9'(i), fz[8*i +: 8]);
    check("dpll_measured_word_a_setting_out", dpll_measured_word_a_setting_out, 40'h0);
    rd(9'h060, 8'h00);
    wr(9'h064, fz[39:32]);
    check("dpll_measured_word_a_setting_out", dpll_measured_word_a_setting_out, fz);
    wa = $urandom;
    for (int i = 0; i < 3; i++) wr(9'h070 + 9'(i), wa[8*i +: 8]);
    wr(9'h060, 8'h5A);
    check("phase_offset_word_out", phase_offset_word_out, 32'h0);
    for (int i = 0; i < 4; i++) wr(9'h070 + 9'(i), wa[8*i +: 8]);
    check("phase_offset_word_out", phase_offset_word_out, wa);
    wa = meas_measured_word_a;
    rd(9'h065, wa[7:0]);
    meas_measured_word_a <= ~wa;
    for (int i = 1; i < 4; i++) rd(9'h065 + 9'(i), wa[8*i +: 8]);
    wa = meas_phase;
    wr(9'h07D, ~wa[7:0]);
    for (int i = 0; i < 4; i++) rd(9'h07D + 9'(i), wa[8*i +: 8]);
    rd(9'h060, fz[7:0]);
    wr(9'h061, ~fz[15:8]);
    rd(9'h061, ~fz[15:8]);
    rd(9'h062, fz[23:16]);
    @(posedge ref_clk);
    evt_in <= 8'h01;
    rd(9'h041, 8'h01);
    rd(9'h042, 8'h01);
    check("irq", irq, 1'b0);
    wr(9'h043, 8'h01);
    @(posedge ref_clk);
    #1;
    check("irq", irq, 1'b1);
    wr(9'h042, 8'h00);
    rd(9'h042, 8'h01);
    wr(9'h042, 8'hFF);
    rd(9'h042, 8'h00);
    check("irq", irq, 1'b0);
    @(posedge ref_clk);
    evt_in <= 8'h00;
    rd(9'h042, 8'h00);
    rd(9'h041, 8'h00);
    wr(9'h009, 8'h80);
    check("soft_rst", soft_rst, 1'b1);
    wr(9'h009, 8'h00);
    rd(9'h00B, 8'h44);
    rd(9'h00E, strap);
    check("dpll_measured_word_a_setting_out", dpll_measured_word_a_setting_out, 40'h0);
    wr(9'h000, 8'h01);
    rd(9'h00B, 8'h0B ^ 8'hA5);
    wr(9'h00B, 8'h3C);
    check("ee_wr", ee_wr, 1'b1);
    check("ee_addr", ee_addr, 9'h00B);
    check("ee_wdata", ee_wdata, 8'h3C);
    rd(9'h000, 8'h01);
    wr(9'h000, 8'h00);
    rd(9'h00B, 8'h44);
    wr(9'h00A, 8'h77);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(9'h00A, 8'h00);
    check("pending reads", exp_q.size(), 40'h0);
    summarize();
  end
endmodule
